// ### core/cmo_fcnt_store.v
// Small register store for the captured frame counter value
`timescale 1ns/100ps
module cmo_fcnt_store #(
   parameter WIDTH = 16
) (
   input  wire             ref_clk,
   input  wire             reset_n,
   input  wire             wr_en,
   input  wire [WIDTH-1:0] wr_data,
   output reg  [WIDTH-1:0] rd_data
);

   always @(posedge ref_clk) begin
      if (!reset_n) begin
         rd_data <= {WIDTH{1'b0}};
      end else if (wr_en) begin
         rd_data <= wr_data;
      end
   end

endmodule // cmo_fcnt_store

// ### core/cmo_object_ctrl.v
// Control and status logic of a set of CAN message objects
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`include "cmo_map.vh"

module cmo_object_ctrl #(
   parameter N_OBJ   = 4,
   parameter OBJ_W   = 2,
   parameter FCNT_W  = 16
) (
   input  wire              ref_clk,
   input  wire              reset_n,
   input  wire [7:0]        reg_addr,
   input  wire [31:0]       reg_wdata,
   input  wire              reg_wr,
   input  wire              reg_rd,
   output reg  [31:0]       reg_rdata,
   input  wire              rx_valid,
   input  wire [28:0]       rx_id,
   input  wire              rx_xtd,
   input  wire              rx_remote,
   input  wire              rx_node,
   input  wire              rx_gateway,
   input  wire [FCNT_W-1:0] frame_count,
   output wire              tx_pending,
   output wire [OBJ_W-1:0]  tx_obj,
   output wire              tx_remote,
   input  wire              tx_start,
   input  wire              tx_done,
   output reg               rx_hit,
   output reg  [OBJ_W-1:0]  rx_hit_obj
);

   // ------------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------------
   function [0:0] pair_next;
      input       cur;
      input [1:0] code;
      begin
         if (code == `CMO_PAIR_SET)
            pair_next = 1'b1;
         else if (code == `CMO_PAIR_CLR)
            pair_next = 1'b0;
         else
            pair_next = cur;
      end
   endfunction

   function [1:0] pair_rd;
      input flag;
      begin
         pair_rd = flag ? `CMO_PAIR_SET : `CMO_PAIR_CLR;
      end
   endfunction

   // ------------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------------
   reg [N_OBJ-1:0] val_reg, newd_reg, lost_reg, send_request_reg, rpnd_reg;
   reg [N_OBJ-1:0] node_reg, xtd_reg, dir_reg, gwen_reg;
   reg [N_OBJ-1:0] node_pend_reg, xtd_pend_reg, dir_pend_reg;
   reg [7:0]       ptr_reg [0:N_OBJ-1];
   reg [7:0]       ptr_pend_reg [0:N_OBJ-1];
   reg [28:0]      id_reg [0:N_OBJ-1];
   reg [28:0]      amask_reg [0:N_OBJ-1];
   reg [N_OBJ-1:0] newd_again_reg;
   reg             busy_reg;
   reg [OBJ_W-1:0] busy_obj_reg;
   reg             busy_rmt_reg;

   wire [3:0]       reg_idx = reg_addr[3:0];
   wire [OBJ_W-1:0] reg_obj = reg_addr[OBJ_W+3:4];
   // Software setting fresh-data this cycle wins over the clear at transmission start
   wire             sw_newd_set = reg_wr && (reg_idx == `CMO_CTRL_IDX) &&
                                  (reg_wdata[`CMO_NEWD_POS+1:`CMO_NEWD_POS] == `CMO_PAIR_SET);

   // ------------------------------------------------------------------------
   // Acceptance match and priority select
   // ------------------------------------------------------------------------
   reg [N_OBJ-1:0] match;
   reg             sel_found;
   reg [OBJ_W-1:0] sel_obj;
   integer         k;

   always @* begin
      match     = {N_OBJ{1'b0}};
      sel_found = 1'b0;
      sel_obj   = {OBJ_W{1'b0}};
      for (k = 0; k < N_OBJ; k = k + 1) begin
         match[k] = val_reg[k] && (node_reg[k] == rx_node) && (xtd_reg[k] == rx_xtd) &&
                    (((id_reg[k] ^ rx_id) & amask_reg[k] &
                      (rx_xtd ? 29'h1fffffff : 29'h1ffc0000)) == 29'h0);
      end
      for (k = N_OBJ - 1; k >= 0; k = k - 1) begin
         if (val_reg[k] && send_request_reg[k] && !lost_reg[k]) begin
            sel_found = 1'b1;
            sel_obj   = k[OBJ_W-1:0];
         end
      end
   end

   // First matching object takes the frame
   reg             hit_any;
   reg [OBJ_W-1:0] hit_obj;
   integer         m;
   always @* begin
      hit_any = 1'b0;
      hit_obj = {OBJ_W{1'b0}};
      for (m = N_OBJ - 1; m >= 0; m = m - 1) begin
         if (match[m]) begin
            hit_any = 1'b1;
            hit_obj = m[OBJ_W-1:0];
         end
      end
   end

   assign tx_pending = sel_found && !busy_reg;
   assign tx_obj     = sel_obj;
   assign tx_remote  = !dir_reg[sel_obj];

   // ------------------------------------------------------------------------
   // Frame count snapshot stores
   // ------------------------------------------------------------------------
   wire [FCNT_W-1:0] fcnt_q [0:N_OBJ-1];
   genvar g;
   generate
      for (g = 0; g < N_OBJ; g = g + 1) begin : g_fcnt
         wire cap = (rx_valid && hit_any && hit_obj == g && !rx_remote && !dir_reg[g]) ||
                    (tx_done && busy_reg && busy_obj_reg == g && !busy_rmt_reg);
         cmo_fcnt_store #(.WIDTH(FCNT_W)) u_fcnt (
            .ref_clk (ref_clk),
            .reset_n (reset_n),
            .wr_en   (cap),
            .wr_data (frame_count),
            .rd_data (fcnt_q[g])
         );
      end
   endgenerate

   // ------------------------------------------------------------------------
   // Flag update
   // ------------------------------------------------------------------------
   integer i;
   always @(posedge ref_clk) begin
      if (!reset_n) begin
         val_reg        <= {N_OBJ{1'b0}};
         newd_reg       <= {N_OBJ{1'b0}};
         lost_reg       <= {N_OBJ{1'b0}};
         send_request_reg       <= {N_OBJ{1'b0}};
         rpnd_reg       <= {N_OBJ{1'b0}};
         node_reg       <= {N_OBJ{1'b0}};
         xtd_reg        <= {N_OBJ{1'b0}};
         dir_reg        <= {N_OBJ{1'b0}};
         gwen_reg       <= {N_OBJ{1'b0}};
         node_pend_reg  <= {N_OBJ{1'b0}};
         xtd_pend_reg   <= {N_OBJ{1'b0}};
         dir_pend_reg   <= {N_OBJ{1'b0}};
         newd_again_reg <= {N_OBJ{1'b0}};
         busy_reg       <= 1'b0;
         busy_obj_reg   <= {OBJ_W{1'b0}};
         busy_rmt_reg   <= 1'b0;
         rx_hit         <= 1'b0;
         rx_hit_obj     <= {OBJ_W{1'b0}};
         for (i = 0; i < N_OBJ; i = i + 1) begin
            ptr_reg[i]      <= 8'h00;
            ptr_pend_reg[i] <= 8'h00;
            id_reg[i]       <= 29'h0;
            amask_reg[i]    <= `CMO_AMASK_RST;
         end
      end else begin
         rx_hit     <= rx_valid && hit_any;
         rx_hit_obj <= hit_obj;
         for (i = 0; i < N_OBJ; i = i + 1) begin
            // Software writes first; hardware events below override them, except the transmission-start clear of a fresh-data set by software
            if (reg_wr && reg_obj == i) begin
               if (reg_idx == `CMO_CTRL_IDX) begin
                  val_reg[i]  <= pair_next(val_reg[i],  reg_wdata[`CMO_VAL_POS+1:`CMO_VAL_POS]);
                  newd_reg[i] <= pair_next(newd_reg[i], reg_wdata[`CMO_NEWD_POS+1:`CMO_NEWD_POS]);
                  lost_reg[i] <= pair_next(lost_reg[i], reg_wdata[`CMO_LOST_POS+1:`CMO_LOST_POS]);
                  send_request_reg[i] <= pair_next(send_request_reg[i], reg_wdata[`CMO_SEND_REQUEST_POS+1:`CMO_SEND_REQUEST_POS]);
                  rpnd_reg[i] <= pair_next(rpnd_reg[i], reg_wdata[`CMO_RPND_POS+1:`CMO_RPND_POS]);
                  if (reg_wdata[`CMO_VAL_POS+1:`CMO_VAL_POS] == `CMO_PAIR_SET) begin
                     node_reg[i] <= node_pend_reg[i];
                     xtd_reg[i]  <= xtd_pend_reg[i];
                     dir_reg[i]  <= dir_pend_reg[i];
                     ptr_reg[i]  <= ptr_pend_reg[i];
                  end
                  if (reg_wdata[`CMO_NEWD_POS+1:`CMO_NEWD_POS] == `CMO_PAIR_SET)
                     newd_again_reg[i] <= 1'b1;
               end else if (reg_idx == `CMO_CFG_IDX) begin
                  node_pend_reg[i] <= reg_wdata[`CMO_CFG_NODE];
                  xtd_pend_reg[i]  <= reg_wdata[`CMO_CFG_XTD];
                  dir_pend_reg[i]  <= reg_wdata[`CMO_CFG_DIR];
                  gwen_reg[i]      <= reg_wdata[`CMO_CFG_GWEN];
                  ptr_pend_reg[i]  <= reg_wdata[`CMO_CFG_PTR_POS+7:`CMO_CFG_PTR_POS];
               end else if (reg_idx == `CMO_AMASK_IDX) begin
                  amask_reg[i] <= reg_wdata[28:0];
               end else if (reg_idx == `CMO_ID_IDX) begin
                  id_reg[i] <= reg_wdata[28:0];
               end
            end
            // Transmission done; a remote frame arriving in the same cycle still sets the request
            if (tx_done && busy_reg && busy_obj_reg == i) begin
               if (busy_rmt_reg || !(newd_again_reg[i] || newd_reg[i])) begin
                  send_request_reg[i] <= 1'b0;
                  rpnd_reg[i] <= 1'b0;
               end
            end
            // Frame reception
            if (rx_valid && hit_any && hit_obj == i) begin
               if (rx_remote && dir_reg[i] && !(rx_gateway && !gwen_reg[i])) begin
                  send_request_reg[i] <= 1'b1;
                  rpnd_reg[i] <= 1'b1;
               end else if (!rx_remote && !dir_reg[i]) begin
                  newd_reg[i] <= 1'b1;
                  if (newd_reg[i])
                     lost_reg[i] <= 1'b1;
                  if (rx_gateway && gwen_reg[i])
                     send_request_reg[i] <= 1'b1;
               end
            end
            // Transmission start: data frames drop the fresh-data mark
            if (tx_start && tx_pending && sel_obj == i && !(sw_newd_set && reg_obj == i)) begin
               if (dir_reg[i])
                  newd_reg[i] <= 1'b0;
               newd_again_reg[i] <= 1'b0;
            end
         end
         if (tx_start && tx_pending) begin
            busy_reg     <= 1'b1;
            busy_obj_reg <= sel_obj;
            busy_rmt_reg <= !dir_reg[sel_obj];
         end else if (tx_done) begin
            busy_reg <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------------
   // Register read
   // ------------------------------------------------------------------------
   always @(posedge ref_clk) begin
      if (!reset_n) begin
         reg_rdata <= 32'h0;
      end else if (reg_rd) begin
         if (reg_idx == `CMO_CTRL_IDX) begin
            reg_rdata <= {fcnt_q[reg_obj],
                          pair_rd(rpnd_reg[reg_obj]), pair_rd(send_request_reg[reg_obj]),
                          pair_rd(lost_reg[reg_obj]), pair_rd(newd_reg[reg_obj]),
                          pair_rd(val_reg[reg_obj]), 6'h00};
         end else if (reg_idx == `CMO_CFG_IDX) begin
            reg_rdata <= {16'h0000, ptr_pend_reg[reg_obj], 3'h0, gwen_reg[reg_obj],
                          dir_pend_reg[reg_obj], xtd_pend_reg[reg_obj], node_pend_reg[reg_obj], 1'b0};
         end else if (reg_idx == `CMO_STAT_IDX) begin
            reg_rdata <= {16'h0000, ptr_reg[reg_obj], 4'h0,
                          dir_reg[reg_obj], xtd_reg[reg_obj], node_reg[reg_obj], busy_reg};
         end else if (reg_idx == `CMO_AMASK_IDX) begin
            reg_rdata <= {3'h7, amask_reg[reg_obj]};
         end else if (reg_idx == `CMO_ID_IDX) begin
            reg_rdata <= {3'h0, id_reg[reg_obj]};
         end else begin
            reg_rdata <= 32'h0;
         end
      end else begin
         reg_rdata <= 32'h0;
      end
   end

endmodule // cmo_object_ctrl

// ### inc/cmo_map.vh
// Register offsets, field positions, reset values and codes for the message object control block
`ifndef CMO_MAP_VH
`define CMO_MAP_VH

// ----------------------------------------------------------------------------
// Register indices (word address bits 3:0 = index, object number in the bits above)
// ----------------------------------------------------------------------------
`define CMO_CTRL_IDX      4'h0
`define CMO_CFG_IDX       4'h1
`define CMO_STAT_IDX      4'h2
`define CMO_AMASK_IDX     4'h3
`define CMO_ID_IDX        4'h4

// ----------------------------------------------------------------------------
// Control/status field positions (low bit of each two-bit pair and of the frame count)
// ----------------------------------------------------------------------------
`define CMO_VAL_POS       6
`define CMO_NEWD_POS      8
`define CMO_LOST_POS      10
`define CMO_SEND_REQUEST_POS      12
`define CMO_RPND_POS      14
`define CMO_FCNT_POS      16

// Two-bit codes
`define CMO_PAIR_CLR      2'h1
`define CMO_PAIR_SET      2'h2

// Configuration bit positions
`define CMO_CFG_NODE      1
`define CMO_CFG_XTD       2
`define CMO_CFG_DIR       3
`define CMO_CFG_GWEN      4
`define CMO_CFG_PTR_POS   8

// Reset values
`define CMO_CFG_RST       16'h0000
`define CMO_FCNT_RST      16'h0000
`define CMO_AMASK_RST     29'h1fffffff

`endif

// ### test/cmo_ctrl_props.sv
// Port assertions for the message object control block
`timescale 1ns/100ps
module cmo_ctrl_props #(
   parameter N_OBJ = 4,
   parameter OBJ_W = 2
) (
   input wire             ref_clk,
   input wire             reset_n,
   input wire [7:0]       reg_addr,
   input wire             reg_wr,
   input wire             reg_rd,
   input wire [31:0]      reg_rdata,
   input wire             rx_valid,
   input wire             tx_pending,
   input wire [OBJ_W-1:0] tx_obj,
   input wire             tx_start,
   input wire             tx_done,
   input wire             rx_hit,
   input wire [OBJ_W-1:0] rx_hit_obj
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   sequence s_read(idx); reg_rd && reg_addr[3:0] == idx && reg_addr[7:6] == 2'h0; endsequence
   sequence s_launch; tx_pending && tx_start; endsequence
   property p_rdata_idle; !reg_rd || reg_addr[3:0] > 4'h4 |=> reg_rdata == 32'h0; endproperty
   property p_pair_read; s_read(4'h0) |=> (^reg_rdata[7:6]) && (^reg_rdata[9:8]) && (^reg_rdata[11:10])
      && (^reg_rdata[13:12]) && (^reg_rdata[15:14]); endproperty
   property p_mask_top; s_read(4'h3) |=> reg_rdata[31:29] == 3'h7; endproperty
   property p_launch_busy; s_launch |=> !tx_pending; endproperty
   property p_busy_until_done; s_launch |=> !tx_pending until tx_done; endproperty
   property p_pending_holds; tx_pending && !tx_start && !reg_wr && !rx_valid |=> tx_pending && $stable(tx_obj);
   endproperty
   property p_hit_cause; rx_hit |-> $past(rx_valid) && rx_hit_obj < N_OBJ; endproperty
   property p_no_hit; !rx_valid |=> !rx_hit; endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
   a_pair_read: assert property (p_pair_read) else $error("control pair not 01 or 10");
   a_mask_top: assert property (p_mask_top) else $error("mask top bits not ones");
   a_launch_busy: assert property (p_launch_busy) else $error("pending after start");
   a_busy_until_done: assert property (p_busy_until_done) else $error("second start before done");
   a_pending_holds: assert property (p_pending_holds) else $error("pending object changed");
   a_hit_cause: assert property (p_hit_cause) else $error("hit without frame");
   a_no_hit: assert property (p_no_hit) else $error("hit pulse without frame");
endmodule // cmo_ctrl_props
bind cmo_object_ctrl cmo_ctrl_props #(.N_OBJ(N_OBJ), .OBJ_W(OBJ_W)) chk_u (.ref_clk(ref_clk), .reset_n(reset_n),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
   .tx_pending(tx_pending), .tx_obj(tx_obj), .tx_start(tx_start), .tx_done(tx_done), .rx_hit(rx_hit),
   .rx_hit_obj(rx_hit_obj));

// ### test/cmo_node_model.sv
// Behavioural CAN node controller facing the message objects
`timescale 1ns/100ps
module cmo_node_model (
   input wire        ref_clk,
   input wire        reset_n,
   input wire        tx_pending,
   input wire [1:0]  tx_obj,
   input wire        tx_remote,
   output reg        rx_valid,
   output reg [28:0] rx_id,
   output reg        rx_xtd,
   output reg        rx_remote,
   output reg        rx_node,
   output reg        rx_gateway,
   output reg [15:0] frame_count,
   output reg        tx_start,
   output reg        tx_done
);
   reg [3:0] tx_budget = 4'h0;
   reg [3:0] tx_delay = 4'h3;
   reg [3:0] cnt = 4'h0;
   reg       busy = 1'b0;
   reg       last_remote = 1'b0;
   reg [1:0] last_obj = 2'h0;
   integer   done_count = 0;
   initial {rx_valid, rx_id, rx_xtd, rx_remote, rx_node, rx_gateway, frame_count, tx_start, tx_done} = 0;
   // One frame at a time; takes the lowest pending object offered
   always @(posedge ref_clk) begin
      tx_start <= 1'b0;
      tx_done <= 1'b0;
      if (rx_valid || tx_done)
         frame_count <= frame_count + 16'h1;
      if (!reset_n)
         busy <= 1'b0;
      else if (busy) begin
         cnt <= cnt - 4'h1;
         if (cnt == 4'h0) begin
            tx_done <= 1'b1;
            busy <= 1'b0;
            done_count <= done_count + 1;
         end
      end else if (tx_pending && tx_budget != 4'h0) begin
         tx_start <= 1'b1;
         busy <= 1'b1;
         cnt <= tx_delay;
         tx_budget <= tx_budget - 4'h1;
         last_obj <= tx_obj;
         last_remote <= tx_remote;
      end
   end
   task send_frame(input [28:0] id, input rem, input node, input gw);
      begin
         @(posedge ref_clk);
         rx_valid <= 1'b1;
         rx_id <= id;
         {rx_remote, rx_node, rx_gateway} <= {rem, node, gw};
         @(posedge ref_clk);
         rx_valid <= 1'b0;
         rx_id <= ~id;
         {rx_remote, rx_node, rx_gateway} <= ~{rem, node, gw};
      end
   endtask
endmodule // cmo_node_model

// ### test/cmo_object_ctrl_bench.sv
// Self-checking bench for the message object control block
`timescale 1ns/100ps
module cmo_object_ctrl_bench;
   localparam [1:0] S = 2'h2, C = 2'h1, K = 2'h3, Z = 2'h0;
   localparam [28:0] ID0 = 29'h00c80000, ID1 = 29'h02940000, ID2 = 29'h05540000;
   reg         ref_clk = 1'b0;
   reg         reset_n = 1'b0;
   reg  [7:0]  reg_addr = 8'h0;
   reg  [31:0] reg_wdata = 32'h0;
   reg         reg_wr = 1'b0;
   reg         reg_rd = 1'b0;
   reg  [15:0] exp_fc = 16'h0;
   wire [31:0] reg_rdata;
   wire [28:0] rx_id;
   wire [15:0] frame_count;
   wire [1:0]  tx_obj, rx_hit_obj;
   wire        rx_valid, rx_xtd, rx_remote, rx_node, rx_gateway, tx_pending, tx_remote, tx_start, tx_done, rx_hit;
   integer     fails = 0;
   integer     samples_checked = 0;
   integer     i;
   always #2.5 ref_clk = ~ref_clk;
   cmo_object_ctrl dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_id(rx_id), .rx_xtd(rx_xtd),
      .rx_remote(rx_remote), .rx_node(rx_node), .rx_gateway(rx_gateway), .frame_count(frame_count),
      .tx_pending(tx_pending), .tx_obj(tx_obj), .tx_remote(tx_remote), .tx_start(tx_start), .tx_done(tx_done),
      .rx_hit(rx_hit), .rx_hit_obj(rx_hit_obj));
   cmo_node_model node_u (.ref_clk(ref_clk), .reset_n(reset_n), .tx_pending(tx_pending), .tx_obj(tx_obj),
      .tx_remote(tx_remote), .rx_valid(rx_valid), .rx_id(rx_id), .rx_xtd(rx_xtd), .rx_remote(rx_remote),
      .rx_node(rx_node), .rx_gateway(rx_gateway), .frame_count(frame_count), .tx_start(tx_start), .tx_done(tx_done));
   function [31:0] ctl(input [1:0] v, input [1:0] n, input [1:0] l, input [1:0] t, input [1:0] r);
      ctl = {16'h0, r, t, l, n, v, 6'h0};
   endfunction
   task results;
      begin
         $display("checks %0d mismatches %0d", samples_checked, fails);
         if (fails == 0 && samples_checked > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   task check(input ok, input [127:0] what);
      begin
         samples_checked = samples_checked + 1;
         if (!ok) begin
            fails = fails + 1;
            $display("mismatch at %0t: %0s", $time, what);
         end
      end
   endtask
   task wr(input [3:0] idx, input [1:0] obj, input [31:0] d);
      begin
         @(posedge ref_clk);
         reg_wr <= 1'b1;
         reg_addr <= {2'h0, obj, idx};
         reg_wdata <= d;
         @(posedge ref_clk);
         reg_wr <= 1'b0;
         #1;
      end
   endtask
   task rd(input [3:0] idx, input [1:0] obj, input [31:0] m, input [31:0] e);
      begin
         @(posedge ref_clk);
         reg_rd <= 1'b1;
         reg_addr <= {2'h0, obj, idx};
         @(posedge ref_clk);
         reg_rd <= 1'b0;
         #1;
         check((reg_rdata & m) === e, "readback");
      end
   endtask
   task frame(input [28:0] id, input rem, input node, input gw, input hit);
      begin
         node_u.send_frame(id, rem, node, gw);
         #1;
         exp_fc = exp_fc + 16'h1;
         check(rx_hit === hit, "rx hit");
      end
   endtask
   task wait_done(input integer n, input [3:0] budget);
      begin
         node_u.tx_budget <= budget;
         for (i = 0; i < 200 && node_u.done_count < n; i = i + 1)
            @(posedge ref_clk);
         check(node_u.done_count == n, "timeout");
         if (i >= 200)
            results;
         @(posedge ref_clk);
         exp_fc = exp_fc + 16'h1;
      end
   endtask
   initial begin
      repeat (12) @(posedge ref_clk);
      reset_n <= 1'b1;
      rd(4'h0, 2'h0, 32'hffffffc0, ctl(C, C, C, C, C));
      wr(4'h0, 2'h0, ctl(K, S, Z, K, Z));
      rd(4'h0, 2'h0, 32'hffc0, ctl(C, S, C, C, C));
      wr(4'h0, 2'h0, ctl(Z, C, K, Z, K));
      rd(4'h0, 2'h0, 32'hffc0, ctl(C, C, C, C, C));
      rd(4'h7, 2'h0, 32'hffffffff, 32'h0);
      rd(4'h3, 2'h1, 32'hffffffff, 32'hffffffff);
      wr(4'h1, 2'h0, 32'h8);
      wr(4'h4, 2'h0, {3'h0, ID0});
      wr(4'h0, 2'h0, ctl(K, S, K, S, K));
      rd(4'h2, 2'h0, 32'he, 32'h0);
      frame(ID0, 1'b1, 1'b0, 1'b0, 1'b0);
      check(tx_pending === 1'b0, "invalid sends");
      wr(4'h0, 2'h0, ctl(S, K, K, K, K));
      rd(4'h2, 2'h0, 32'he, 32'h8);
      wr(4'h0, 2'h1, ctl(S, K, K, S, K));
      check(tx_pending === 1'b1 && tx_obj === 2'h0 && tx_remote === 1'b0, "priority");
      wait_done(1, 4'h1);
      check(node_u.last_obj === 2'h0 && node_u.last_remote === 1'b0, "first frame");
      rd(4'h0, 2'h0, 32'hffffffc0, {exp_fc - 16'h1, 16'h0} | ctl(S, C, C, C, C));
      wait_done(2, 4'h1);
      check(node_u.last_obj === 2'h1 && node_u.last_remote === 1'b1, "remote frame");
      rd(4'h0, 2'h1, 32'hffc0, ctl(S, C, C, C, C));
      wr(4'h0, 2'h0, ctl(K, K, S, S, K));
      check(tx_pending === 1'b0, "locked sends");
      frame(ID0, 1'b1, 1'b0, 1'b0, 1'b1);
      rd(4'h0, 2'h0, 32'hffc0, ctl(S, C, S, S, S));
      check(tx_pending === 1'b0, "locked sends");
      node_u.tx_delay <= 4'h0;
      wr(4'h0, 2'h0, ctl(K, S, C, K, K));
      wait_done(3, 4'h1);
      rd(4'h0, 2'h0, 32'hffffffc0, {exp_fc - 16'h1, 16'h0} | ctl(S, C, C, C, C));
      node_u.tx_delay <= 4'h8;
      wr(4'h0, 2'h0, ctl(K, S, K, S, K));
      node_u.tx_budget <= 4'h1;
      repeat (4) @(posedge ref_clk);
      wr(4'h0, 2'h0, ctl(K, S, K, K, K));
      wait_done(4, 4'h0);
      rd(4'h0, 2'h0, 32'hffc0, ctl(S, S, C, S, C));
      wr(4'h0, 2'h0, ctl(K, C, K, C, K));
      wr(4'h1, 2'h1, 32'h2);
      wr(4'h3, 2'h1, 32'h1ffbffff);
      wr(4'h4, 2'h1, {3'h0, ID1});
      wr(4'h0, 2'h1, ctl(S, K, K, K, K));
      rd(4'h2, 2'h1, 32'he, 32'h2);
      frame(ID1 ^ 29'h40000, 1'b0, 1'b1, 1'b0, 1'b1);
      check(rx_hit_obj === 2'h1, "hit object");
      rd(4'h0, 2'h1, 32'hffffffc0, {exp_fc - 16'h1, 16'h0} | ctl(S, S, C, C, C));
      frame(ID1, 1'b0, 1'b1, 1'b0, 1'b1);
      rd(4'h0, 2'h1, 32'hffc0, ctl(S, S, S, C, C));
      wr(4'h0, 2'h1, ctl(K, C, C, K, K));
      frame(ID1 ^ 29'h80000, 1'b0, 1'b1, 1'b0, 1'b0);
      rd(4'h0, 2'h1, 32'hffc0, ctl(S, C, C, C, C));
      wr(4'h4, 2'h2, {3'h0, ID2});
      for (i = 0; i < 2; i = i + 1) begin
         wr(4'h1, 2'h2, i[0] ? 32'h10 : 32'h0);
         wr(4'h0, 2'h2, ctl(S, C, K, C, K));
         frame(ID2, 1'b0, 1'b0, 1'b1, 1'b1);
         rd(4'h0, 2'h2, 32'h3000, ctl(C, C, C, i[0] ? S : C, C) & 32'h3000);
      end
      results;
   end
endmodule // cmo_object_ctrl_bench
